//--- logic/arl_timer_consts.vh
/*
 * Constants for the split-capable auto-reload timer: register
 * addresses, field positions, reset values and clock divisors.
 * Assumes it is included by bare name from logic/ sources only.
 */
`ifndef ARL_TIMER_CONSTS_VH
`define ARL_TIMER_CONSTS_VH

// ----------------------------------------------------------------
// Register addresses, valid only while page F is selected.
// ----------------------------------------------------------------
`define ADDR_TIMER_CONTROL 8'h91
`define ADDR_RELOAD_LOW 8'h92
`define ADDR_RELOAD_HIGH 8'h93
`define ADDR_COUNT_LOW 8'h94
`define ADDR_COUNT_HIGH 8'h95

// ----------------------------------------------------------------
// Field positions of timer_control.
// ----------------------------------------------------------------
`define BIT_HIGH_FLAG 7
`define BIT_LOW_FLAG 6
`define BIT_LOW_IRQ_EN 5
`define BIT_SPLIT 3
`define BIT_RUN 2
`define BIT_EXT_CLK 0

// ----------------------------------------------------------------
// Reset values, byte limits and read value of unused space.
// ----------------------------------------------------------------
`define RESET_BYTE 8'h00
`define BYTE_MAX 8'hff
`define WORD_MAX 16'hffff
`define READ_ZERO 8'h00

// ----------------------------------------------------------------
// Clock prescaler divisors and counter widths.
// ----------------------------------------------------------------
`define SYS_DIVISOR 12
`define EXT_DIVISOR 8
`define SYS_DIV_W 4
`define EXT_DIV_W 3

`endif

//--- logic/arl_tick_gen.v
/*
 * Tick generator: one-cycle enables at the system clock divided by
 * the system divisor, and at the external clock divided by the
 * external divisor after synchronising that clock to clk.
 * Assumes ext_clk_in is a slow level sampled on clk.
 */
`timescale 1ns/1ps
`default_nettype none
`include "arl_timer_consts.vh"

module arl_tick_gen #(
    parameter SYS_DIV = `SYS_DIVISOR,
    parameter EXT_DIV = `EXT_DIVISOR
) (
    input wire clk,
    input wire rstn,
    input wire ext_clk_in,
    output reg sys_tick_q,
    output reg ext_tick_q
);

    // Prescaler counters and the external clock synchroniser.
    reg [`SYS_DIV_W-1:0] sys_cnt_q;
    reg [`EXT_DIV_W-1:0] ext_cnt_q;
    reg sync1_q;
    reg sync2_q;
    reg sync3_q;

    // Terminal counts, cut to the counter widths on purpose.
    localparam integer SYS_LAST_I = SYS_DIV - 1;
    localparam integer EXT_LAST_I = EXT_DIV - 1;
    localparam [`SYS_DIV_W-1:0] SYS_LAST = SYS_LAST_I[`SYS_DIV_W-1:0];
    localparam [`EXT_DIV_W-1:0] EXT_LAST = EXT_LAST_I[`EXT_DIV_W-1:0];

    // ------------------------------------------------------------
    // System prescaler.
    // ------------------------------------------------------------
    // Free running, so a byte sees its first tick within one period.
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sys_cnt_q <= {`SYS_DIV_W{1'b0}};
            sys_tick_q <= 1'b0;
        end else if (sys_cnt_q == SYS_LAST) begin
            sys_cnt_q <= {`SYS_DIV_W{1'b0}};
            sys_tick_q <= 1'b1;
        end else begin
            sys_cnt_q <= sys_cnt_q + 1'b1;
            sys_tick_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // External clock synchroniser and divider.
    // ------------------------------------------------------------
    // Only sync2/sync3 feed the edge detector; sync1 may be
    // metastable and is read by sync2 alone. [RQ9]
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            sync3_q <= 1'b0;
            ext_cnt_q <= {`EXT_DIV_W{1'b0}};
            ext_tick_q <= 1'b0;
        end else begin
            sync1_q <= ext_clk_in;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            ext_tick_q <= 1'b0;
            // Count rising edges; every eighth one is a tick. [RQ8]
            if (sync2_q && !sync3_q) begin
                if (ext_cnt_q == EXT_LAST) begin
                    ext_cnt_q <= {`EXT_DIV_W{1'b0}};
                    ext_tick_q <= 1'b1;
                end else begin
                    ext_cnt_q <= ext_cnt_q + 1'b1;
                end
            end
        end
    end

endmodule

`default_nettype wire

//--- logic/arl_timer.v
/*
 * Auto-reload timer, either one 16-bit counter or two independent
 * 8-bit counters, with byte overflow flags and an interrupt request.
 * Assumes a byte-wide special-register port with single-cycle read
 * and write strobes, and the CPU's enable and prescale bits as pins.
 */
// Function
// [RQ1] Split clear chains bytes into 16 bits
// [RQ2] 16-bit wrap reloads and sets high flag
// [RQ3] 16-bit overflow requests interrupt when enabled
// [RQ4] Low-byte wrap interrupts if low enable set
// [RQ5] Split set gives two 8-bit timers
// [RQ6] Each byte reloads from its own reload
// [RQ7] Run gates high byte; low always runs
// [RQ8] Fast select, else divide-by-12 or external/8
// [RQ9] External divided clock synchronised to system clock
// [RQ10] Split byte wraps set their own flags
// [RQ11] Split interrupts on high, low if enabled
// [RQ12] Flags cleared only by software writes
// [RQ13] Handler reads both flags to find source
// [RQ14] Low flag set on every low wrap
// [RQ15] Control at 0x91 page F, reset zero
// [RQ16] Unused bit four reads zero, ignores writes
// [RQ17] Run bit enables the whole 16-bit counter
// [RQ18] Capture enable absent, treated as zero
`timescale 1ns/1ps
`default_nettype none
`include "arl_timer_consts.vh"

module arl_timer #(
    parameter SYS_DIV = `SYS_DIVISOR,
    parameter EXT_DIV = `EXT_DIVISOR
) (
    input wire clk,
    input wire rstn,
    input wire [7:0] sfr_addr,
    input wire sfr_page_f,
    input wire sfr_wr,
    input wire [7:0] sfr_wdata,
    input wire sfr_rd,
    output reg [7:0] sfr_rdata_q,
    input wire extended_interrupt_enable,
    input wire high_byte_fast_clock_select,
    input wire low_byte_fast_clock_select,
    input wire ext_clk_in,
    output wire irq_request
);

    // ------------------------------------------------------------
    // Register state.
    // ------------------------------------------------------------
    // Flags set by hardware and written by software.
    reg high_overflow_flag_q;
    reg low_overflow_flag_q;
    // Software controls.
    reg low_byte_irq_enable_q;
    reg split_mode_select_q;
    reg run_control_q;
    reg ext_clock_select_q;
    // Reload and count bytes.
    reg [7:0] reload_low_byte_q;
    reg [7:0] reload_high_byte_q;
    reg [7:0] count_low_byte_q;
    reg [7:0] count_high_byte_q;

    // Next values of the count bytes and flags.
    reg [7:0] count_low_byte_d;
    reg [7:0] count_high_byte_d;
    reg high_wrap;
    reg low_wrap;

    // Prescaler ticks from the tick generator.
    wire sys_tick;
    wire ext_tick;

    // ------------------------------------------------------------
    // Helpers.
    // ------------------------------------------------------------
    // Address match on page F; used for every register decode.
    function sel;
        input [7:0] addr;
        input [7:0] target;
        input page;
        begin
            sel = page && (addr == target);
        end
    endfunction

    // Per-byte clock source choice, shared by both bytes. [RQ8]
    function pick_tick;
        input fast;
        input ext_sel;
        input s_tick;
        input e_tick;
        begin
            if (fast) begin
                pick_tick = 1'b1;
            end else if (ext_sel) begin
                pick_tick = e_tick;
            end else begin
                pick_tick = s_tick;
            end
        end
    endfunction

    // Write strobes for each register.
    wire wr_ctl = sfr_wr && sel(sfr_addr, `ADDR_TIMER_CONTROL,
        sfr_page_f); // [RQ15]
    wire wr_rll = sfr_wr && sel(sfr_addr, `ADDR_RELOAD_LOW,
        sfr_page_f);
    wire wr_rlh = sfr_wr && sel(sfr_addr, `ADDR_RELOAD_HIGH,
        sfr_page_f);
    wire wr_cl = sfr_wr && sel(sfr_addr, `ADDR_COUNT_LOW,
        sfr_page_f);
    wire wr_ch = sfr_wr && sel(sfr_addr, `ADDR_COUNT_HIGH,
        sfr_page_f);

    // The capture mode does not exist here, so split alone picks
    // the two-byte arrangement. [RQ18]
    wire split_on = split_mode_select_q;

    // Byte tick enables.
    wire low_tick = pick_tick(low_byte_fast_clock_select,
        ext_clock_select_q, sys_tick, ext_tick);
    wire high_tick = pick_tick(high_byte_fast_clock_select,
        ext_clock_select_q, sys_tick, ext_tick);

    // ------------------------------------------------------------
    // Prescaler.
    // ------------------------------------------------------------
    arl_tick_gen #(
        .SYS_DIV(SYS_DIV),
        .EXT_DIV(EXT_DIV)
    ) u_ticks (
        .clk(clk),
        .rstn(rstn),
        .ext_clk_in(ext_clk_in),
        .sys_tick_q(sys_tick),
        .ext_tick_q(ext_tick)
    );

    // ------------------------------------------------------------
    // Counting.
    // ------------------------------------------------------------
    // The 16-bit mode clocks from the low byte's source selection,
    // since one counter cannot follow two sources. The high byte's
    // fast select is then ignored, which the user must keep in mind.
    // Both wraps are decided from the present count, so the flag of
    // a byte rises on the same edge on which that byte wraps.
    always @* begin
        count_low_byte_d = count_low_byte_q;
        count_high_byte_d = count_high_byte_q;
        high_wrap = 1'b0;
        low_wrap = 1'b0;
        if (!split_on) begin
            // Chained counter, gated by run as a whole. [RQ1] [RQ17]
            if (run_control_q && low_tick) begin
                if (count_low_byte_q == `BYTE_MAX) begin
                    low_wrap = 1'b1; // [RQ14]
                end
                if ({count_high_byte_q, count_low_byte_q} ==
                        `WORD_MAX) begin
                    // Full wrap loads the 16-bit reload. [RQ2]
                    high_wrap = 1'b1;
                    count_low_byte_d = reload_low_byte_q;
                    count_high_byte_d = reload_high_byte_q;
                end else if (count_low_byte_q == `BYTE_MAX) begin
                    count_low_byte_d = `RESET_BYTE;
                    count_high_byte_d = count_high_byte_q + 1'b1;
                end else begin
                    count_low_byte_d = count_low_byte_q + 1'b1;
                end
            end
        end else begin
            // Low byte always counts in split mode. [RQ5] [RQ7]
            if (low_tick) begin
                if (count_low_byte_q == `BYTE_MAX) begin
                    low_wrap = 1'b1; // [RQ10] [RQ14]
                    count_low_byte_d = reload_low_byte_q; // [RQ6]
                end else begin
                    count_low_byte_d = count_low_byte_q + 1'b1;
                end
            end
            // High byte counts only while run is set. [RQ7]
            if (run_control_q && high_tick) begin
                if (count_high_byte_q == `BYTE_MAX) begin
                    high_wrap = 1'b1; // [RQ10]
                    count_high_byte_d = reload_high_byte_q; // [RQ6]
                end else begin
                    count_high_byte_d = count_high_byte_q + 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Register updates.
    // ------------------------------------------------------------
    // A software write to a count byte wins over counting in that
    // cycle, but a wrap in the same cycle still sets its flag.
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            high_overflow_flag_q <= 1'b0; // [RQ15]
            low_overflow_flag_q <= 1'b0;
            low_byte_irq_enable_q <= 1'b0;
            split_mode_select_q <= 1'b0;
            run_control_q <= 1'b0;
            ext_clock_select_q <= 1'b0;
            reload_low_byte_q <= `RESET_BYTE;
            reload_high_byte_q <= `RESET_BYTE;
            count_low_byte_q <= `RESET_BYTE;
            count_high_byte_q <= `RESET_BYTE;
        end else begin
            // Control fields; bits 4 and 1 are not stored. [RQ16]
            if (wr_ctl) begin
                low_byte_irq_enable_q <= sfr_wdata[`BIT_LOW_IRQ_EN];
                split_mode_select_q <= sfr_wdata[`BIT_SPLIT];
                run_control_q <= sfr_wdata[`BIT_RUN];
                ext_clock_select_q <= sfr_wdata[`BIT_EXT_CLK];
            end
            // Flags: a hardware set beats a software clear, and
            // only software ever clears. [RQ12]
            if (high_wrap) begin
                high_overflow_flag_q <= 1'b1; // [RQ2] [RQ10]
            end else if (wr_ctl) begin
                high_overflow_flag_q <= sfr_wdata[`BIT_HIGH_FLAG];
            end
            if (low_wrap) begin
                low_overflow_flag_q <= 1'b1; // [RQ14]
            end else if (wr_ctl) begin
                low_overflow_flag_q <= sfr_wdata[`BIT_LOW_FLAG];
            end
            // Reload bytes.
            if (wr_rll) begin
                reload_low_byte_q <= sfr_wdata;
            end
            if (wr_rlh) begin
                reload_high_byte_q <= sfr_wdata;
            end
            // Count bytes.
            if (wr_cl) begin
                count_low_byte_q <= sfr_wdata;
            end else begin
                count_low_byte_q <= count_low_byte_d;
            end
            if (wr_ch) begin
                count_high_byte_q <= sfr_wdata;
            end else begin
                count_high_byte_q <= count_high_byte_d;
            end
        end
    end

    // ------------------------------------------------------------
    // Read port.
    // ------------------------------------------------------------
    // Data appear the edge after the read strobe; any other address
    // or page reads zero. Registering the data keeps the bus output
    // free of glitches, at the cost of one cycle on every read.
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sfr_rdata_q <= `READ_ZERO;
        end else if (sfr_rd) begin
            sfr_rdata_q <= `READ_ZERO;
            if (sel(sfr_addr, `ADDR_TIMER_CONTROL, sfr_page_f)) begin
                // Unused bits stay zero. [RQ16]
                sfr_rdata_q[`BIT_HIGH_FLAG] <= high_overflow_flag_q;
                sfr_rdata_q[`BIT_LOW_FLAG] <= low_overflow_flag_q;
                sfr_rdata_q[`BIT_LOW_IRQ_EN] <= low_byte_irq_enable_q;
                sfr_rdata_q[`BIT_SPLIT] <= split_mode_select_q;
                sfr_rdata_q[`BIT_RUN] <= run_control_q;
                sfr_rdata_q[`BIT_EXT_CLK] <= ext_clock_select_q;
            end else if (sel(sfr_addr, `ADDR_RELOAD_LOW,
                    sfr_page_f)) begin
                sfr_rdata_q <= reload_low_byte_q;
            end else if (sel(sfr_addr, `ADDR_RELOAD_HIGH,
                    sfr_page_f)) begin
                sfr_rdata_q <= reload_high_byte_q;
            end else if (sel(sfr_addr, `ADDR_COUNT_LOW,
                    sfr_page_f)) begin
                sfr_rdata_q <= count_low_byte_q;
            end else if (sel(sfr_addr, `ADDR_COUNT_HIGH,
                    sfr_page_f)) begin
                sfr_rdata_q <= count_high_byte_q;
            end
        end
    end

    // ------------------------------------------------------------
    // Interrupt request.
    // ------------------------------------------------------------
    // A level that follows the flags, so it holds until software
    // clears them; with low enable set the handler must read both
    // flags to tell the source apart. [RQ3] [RQ4] [RQ11] [RQ13]
    // Being combinational, the request drops in the same cycle as a
    // software clear, so no stale request outlives the handler.
    assign irq_request = extended_interrupt_enable &&
        (high_overflow_flag_q ||
        (low_byte_irq_enable_q && low_overflow_flag_q));

endmodule

`default_nettype wire

//--- tb/arl_timer_assertions.sv
/*
 * Checker for the split-capable auto-reload timer, bound to arl_timer.
 * Assumes it sees only the top ports, on one clock with an async
 * active-low reset, and that software alone writes the registers.
 */
`timescale 1ns/1ps
`default_nettype none

module arl_timer_checker #(
    parameter SYS_DIV = 12,
    parameter EXT_DIV = 8
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_page_f,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_rdata_q,
    input wire logic extended_interrupt_enable,
    input wire logic high_byte_fast_clock_select,
    input wire logic low_byte_fast_clock_select,
    input wire logic ext_clk_in,
    input wire logic irq_request
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);

    // ----------------------------------------------------------
    // Shadow of what software wrote and what it last saw.
    // ----------------------------------------------------------
    // Strobes qualified by page F and an address.
    wire ctl_rd = sfr_rd && sfr_page_f && sfr_addr == 8'h91;
    wire ctl_wr = sfr_wr && sfr_page_f && sfr_addr == 8'h91;
    wire mapped = sfr_page_f && sfr_addr >= 8'h91 && sfr_addr <= 8'h95;
    logic [3:0] cfg_q; // Written bits 5, 3, 2 and 0.
    logic [15:0] rl_q; // Written reload bytes.
    logic [1:0] seen_q; // Flags seen set since the last control write.
    logic rd_ctl_q; // A control read without a write landed last edge.

    // Only software changes the config bits and reload bytes, so
    // the shadow may track writes alone; flags only ever rise.
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cfg_q <= 4'h0;
            rl_q <= 16'h0000;
            seen_q <= 2'b00;
            rd_ctl_q <= 1'b0;
        end else begin
            rd_ctl_q <= ctl_rd && !ctl_wr;
            if (ctl_wr) begin
                cfg_q <= {sfr_wdata[5], sfr_wdata[3:2], sfr_wdata[0]};
                seen_q <= 2'b00;
            end else if (rd_ctl_q) begin
                seen_q <= sfr_rdata_q[7:6];
            end
            if (sfr_wr && sfr_page_f && sfr_addr == 8'h92) begin
                rl_q[7:0] <= sfr_wdata;
            end
            if (sfr_wr && sfr_page_f && sfr_addr == 8'h93) begin
                rl_q[15:8] <= sfr_wdata;
            end
        end
    end

    // ----------------------------------------------------------
    // Assertions.
    // ----------------------------------------------------------
    AST_UNMAPPED_ZERO: assert property (
        sfr_rd && !mapped |=> sfr_rdata_q == 8'h00)
        else $error("unmapped read not zero");
    AST_UNUSED_BITS: assert property (
        ctl_rd |=> sfr_rdata_q[4] == 1'b0 && sfr_rdata_q[1] == 1'b0)
        else $error("unused control bit reads one");
    AST_RDATA_HOLD: assert property (
        !sfr_rd |=> $stable(sfr_rdata_q))
        else $error("read data moved without a read");
    AST_IRQ_GATED: assert property (
        !extended_interrupt_enable |-> !irq_request)
        else $error("interrupt without enable");
    AST_IRQ_SOURCE: assert property (
        ctl_rd |=> $past(irq_request) == ($past(extended_interrupt_enable)
            & (sfr_rdata_q[7] | (sfr_rdata_q[5] & sfr_rdata_q[6]))))
        else $error("interrupt disagrees with flags");
    AST_HIGH_STICKY: assert property (
        ctl_rd && seen_q[1] |=> sfr_rdata_q[7])
        else $error("high flag cleared by hardware");
    AST_LOW_STICKY: assert property (
        ctl_rd && seen_q[0] |=> sfr_rdata_q[6])
        else $error("low flag cleared by hardware");
    AST_CFG_READBACK: assert property (
        ctl_rd |=> {sfr_rdata_q[5], sfr_rdata_q[3:2], sfr_rdata_q[0]}
            == $past(cfg_q))
        else $error("control bits differ from write");
    AST_RELOAD_READBACK: assert property (
        sfr_rd && sfr_page_f && sfr_addr == 8'h92 |=>
            sfr_rdata_q == $past(rl_q[7:0]))
        else $error("reload low differs from write");

    // ----------------------------------------------------------
    // Covers for the main scenarios.
    // ----------------------------------------------------------
    COV_HIGH: cover property (ctl_rd ##1 sfr_rdata_q[7]);
    COV_LOW_ONLY: cover property (ctl_rd ##1 sfr_rdata_q[7:6] == 2'b01);
    COV_IRQ: cover property ($rose(irq_request));
endmodule

bind arl_timer arl_timer_checker #(.SYS_DIV(SYS_DIV), .EXT_DIV(EXT_DIV))
    chk_i (.clk(clk), .rstn(rstn), .sfr_addr(sfr_addr),
    .sfr_page_f(sfr_page_f), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
    .sfr_rd(sfr_rd), .sfr_rdata_q(sfr_rdata_q),
    .extended_interrupt_enable(extended_interrupt_enable),
    .high_byte_fast_clock_select(high_byte_fast_clock_select),
    .low_byte_fast_clock_select(low_byte_fast_clock_select),
    .ext_clk_in(ext_clk_in), .irq_request(irq_request));

`default_nettype wire

//--- tb/testbench.sv
/*
 * Self-checking bench for arl_timer through its register port.
 * Assumes shortened divisors and an external clock made here, so that
 * every tick is counted exactly.
 */
`timescale 1ns/1ps
`default_nettype none

module testbench;
    // Inputs change on the falling edge only.
    logic clk, rstn, page_f, wr, rd, ext_en, hi_fast, lo_fast, ext_clk;
    logic [7:0] addr, wdata, a;
    wire [7:0] rdata;
    wire irq;
    int num_errors = 0;
    int n_checks = 0;

    arl_timer #(.SYS_DIV(4), .EXT_DIV(2)) uut (.clk(clk), .rstn(rstn),
        .sfr_addr(addr), .sfr_page_f(page_f), .sfr_wr(wr),
        .sfr_wdata(wdata), .sfr_rd(rd), .sfr_rdata_q(rdata),
        .extended_interrupt_enable(ext_en),
        .high_byte_fast_clock_select(hi_fast),
        .low_byte_fast_clock_select(lo_fast), .ext_clk_in(ext_clk),
        .irq_request(irq));

    // 25 MHz system clock.
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // ----------------------------------------------------------
    // Tasks.
    // ----------------------------------------------------------
    task automatic end_sim;
        if (num_errors == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: byte %h not %h", $time, got, exp);
        end
    endtask
    task automatic chk_irq(input logic exp);
        n_checks++;
        if (irq !== exp) begin
            num_errors++;
            $display("wrong value at %0t: irq %b not %b", $time, irq, exp);
        end
    endtask
    // One-cycle strobes; read data is taken one edge after the strobe.
    task automatic wr_reg(input logic [7:0] ad, input logic [7:0] d);
        @(negedge clk);
        addr = ad;
        wdata = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] ad, output logic [7:0] d);
        @(negedge clk);
        addr = ad;
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        d = rdata;
    endtask
    task automatic rd_chk(input logic [7:0] ad, input logic [7:0] exp);
        logic [7:0] d;
        rd_reg(ad, d);
        chk_byte(d, exp);
    endtask
    // Whole ticks only, two external edges each, so the divider
    // phase never drifts between scenarios.
    task automatic ext_ticks(input int n);
        repeat (2 * n) begin
            ext_clk = 1'b1;
            repeat (4) @(negedge clk);
            ext_clk = 1'b0;
            repeat (4) @(negedge clk);
        end
        repeat (4) @(negedge clk);
    endtask
    // Counts advanced between two reads gap + 2 cycles apart.
    task automatic rate(input logic [7:0] ad, input int gap,
                        input logic [7:0] exp);
        logic [7:0] d0, d1;
        rd_reg(ad, d0);
        repeat (gap) @(negedge clk);
        rd_reg(ad, d1);
        chk_byte(d1 - d0, exp);
    endtask

    // ----------------------------------------------------------
    // Main sequence.
    // ----------------------------------------------------------
    initial begin
        rstn = 1'b0;
        {page_f, wr, rd, ext_en, hi_fast, lo_fast, ext_clk} = 7'h40;
        addr = 8'h00;
        wdata = 8'h00;
        repeat (3) @(negedge clk);
        rstn = 1'b1;
        for (a = 8'h91; a != 8'h96; a++) rd_chk(a, 8'h00);
        wr_reg(8'h91, 8'hff);
        rd_chk(8'h91, 8'hed);
        wr_reg(8'h91, 8'h00);
        rd_chk(8'h91, 8'h00);
        page_f = 1'b0;
        wr_reg(8'h91, 8'h04);
        rd_chk(8'h91, 8'h00);
        page_f = 1'b1;
        rd_chk(8'h91, 8'h00);
        rd_chk(8'h96, 8'h00);
        // 16-bit wrap from 0xfffe over two external ticks.
        wr_reg(8'h92, 8'h34);
        wr_reg(8'h93, 8'h12);
        wr_reg(8'h94, 8'hfe);
        wr_reg(8'h95, 8'hff);
        wr_reg(8'h91, 8'h05);
        ext_ticks(2);
        rd_chk(8'h94, 8'h34);
        rd_chk(8'h95, 8'h12);
        rd_chk(8'h91, 8'hc5);
        rd_chk(8'h92, 8'h34);
        chk_irq(1'b0);
        ext_en = 1'b1;
        #1 chk_irq(1'b1);
        rd_chk(8'h91, 8'hc5);
        wr_reg(8'h91, 8'h05);
        rd_chk(8'h91, 8'h05);
        chk_irq(1'b0);
        ext_ticks(1);
        rd_chk(8'h94, 8'h35);
        rd_chk(8'h95, 8'h12);
        // Low-byte wrap inside 16-bit mode.
        wr_reg(8'h94, 8'hff);
        wr_reg(8'h95, 8'h20);
        wr_reg(8'h91, 8'h25);
        ext_ticks(1);
        rd_chk(8'h94, 8'h00);
        rd_chk(8'h95, 8'h21);
        rd_chk(8'h91, 8'h65);
        chk_irq(1'b1);
        wr_reg(8'h91, 8'h45);
        chk_irq(1'b0);
        wr_reg(8'h91, 8'h01);
        wr_reg(8'h94, 8'h10);
        ext_ticks(2);
        rd_chk(8'h94, 8'h10);
        // Split mode, high byte stopped first, then running.
        wr_reg(8'h92, 8'h80);
        wr_reg(8'h93, 8'h40);
        wr_reg(8'h94, 8'hff);
        wr_reg(8'h95, 8'hfe);
        wr_reg(8'h91, 8'h09);
        ext_ticks(2);
        rd_chk(8'h94, 8'h81);
        rd_chk(8'h95, 8'hfe);
        rd_chk(8'h91, 8'h49);
        chk_irq(1'b0);
        wr_reg(8'h91, 8'h0d);
        ext_ticks(2);
        rd_chk(8'h94, 8'h83);
        rd_chk(8'h95, 8'h40);
        rd_chk(8'h91, 8'h8d);
        chk_irq(1'b1);
        wr_reg(8'h91, 8'h29);
        wr_reg(8'h94, 8'hff);
        ext_ticks(1);
        rd_chk(8'h91, 8'h69);
        chk_irq(1'b1);
        // Clock sources per byte: fast, then system divided.
        wr_reg(8'h91, 8'h0d);
        lo_fast = 1'b1;
        rate(8'h94, 0, 8'h02);
        rate(8'h95, 0, 8'h00);
        lo_fast = 1'b0;
        hi_fast = 1'b1;
        rate(8'h95, 0, 8'h02);
        rate(8'h94, 0, 8'h00);
        hi_fast = 1'b0;
        wr_reg(8'h91, 8'h0c);
        rate(8'h94, 14, 8'h04);
        rate(8'h95, 14, 8'h04);
        end_sim();
    end
endmodule

`default_nettype wire
